/* hdl/drive_ctl.sv */
// Control word interpreter and status word builder of a frequency converter, with an APB register file.
// Assumes synchronous terminal inputs and an APB master on the same 100 MHz clock.
`include "drive_ctl_defines.svh"
`default_nettype none
module drive_ctl
	import drive_ctl_pkg::*;
#(
	parameter int TIMEOUT_DEFAULT = 32'd100_000_000
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire terminals_t term_in,
	input wire faults_t fault_in,
	input wire logic [63:0] presets_in,
	output logic relay1_out,
	output logic relay2_out,
	output logic output_on_out,
	output logic dc_brake_out,
	output logic reverse_out,
	output logic [1:0] setup_out,
	output logic trip_reset_out
);
	logic [15:0] ctrl_r;
	logic [15:0] ref_r;
	logic [31:0] config_r;
	logic [31:0] timeout_r;
	logic [15:0] jog_r;
	logic [15:0] freq_r;
	logic [15:0] freq_nxt;
	logic [31:0] idle_cnt_r;
	logic prev_reset_r;
	logic relay1_r;
	logic relay2_r;
	logic [15:0] status_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic trip_pulse_r;
	logic [1:0] setup_r;
	logic reverse_r;
	logic output_on_r;
	logic dc_brake_r;
	motor_state_t state_r;
	motor_state_t state_nxt;

	function automatic logic gate_src(input logic [1:0] sel, input logic bus, input logic pin);
		unique case (sel)
			SRC_DIGITAL: gate_src = pin;
			SRC_BUS: gate_src = bus;
			SRC_AND: gate_src = bus & pin;
			default: gate_src = bus | pin;
		endcase
	endfunction

	wire apb_setup = psel_in & ~penable_in;
	wire apb_wr = psel_in & penable_in & pready_r & pwrite_in;
	wire hit_ctrl = paddr_in == `OFS_CTRL_IN;
	wire hit_ref = paddr_in == `OFS_REF_IN;
	wire hit_cfg = paddr_in == `OFS_CONFIG;
	wire hit_tmo = paddr_in == `OFS_TIMEOUT;
	wire hit_jog = paddr_in == `OFS_JOG;
	wire hit_sts = paddr_in == `OFS_STATUS;
	wire hit_frq = paddr_in == `OFS_OUTFREQ;
	wire hit_drv = paddr_in == `OFS_DRIVE;
	wire hit_flt = paddr_in == `OFS_FAULT;
	// Read-only words take writes without an error, so a master may write a whole block back.
	wire hit_ro = hit_sts | hit_frq | hit_drv | hit_flt;
	wire mapped = hit_ctrl | hit_ref | hit_cfg | hit_tmo | hit_jog | hit_ro;
	// A control word without its valid bit is dropped whole, so nothing in it takes effect.
	wire cw_wr = apb_wr & hit_ctrl & pwdata_in[`CW_VALID];
	// The reference travels with the control word, so it is also taken only while that word is valid.
	wire ref_wr = apb_wr & hit_ref & ctrl_r[`CW_VALID];
	wire timed_out = timeout_r != 32'h0000_0000 && idle_cnt_r >= timeout_r;

	wire cfg_multi = config_r[`CFG_MULTI_SETUP];
	wire [1:0] rev_src = config_r[`CFG_REV_SRC_LO +: 2];
	wire [1:0] start_src = config_r[`CFG_START_SRC_LO +: 2];
	wire frozen = ~ctrl_r[`CW_FREEZE];
	wire coast_cmd = ~ctrl_r[`CW_COAST] | ~term_in.coast_n;
	wire brake_cmd = ~ctrl_r[`CW_DCBRAKE] | ~term_in.dcbrake_n;
	wire qstop_cmd = ~ctrl_r[`CW_QSTOP];
	wire start_ok = gate_src(start_src, ctrl_r[`CW_START], term_in.start);
	wire tripped = fault_in.trip | fault_in.trip_lock;
	// Bit 09 feeds nothing, whatever its value.
	wire [1:0] preset_sel = ctrl_r[`CW_PRESET_LO +: 2];
	wire [15:0] preset_ref = presets_in[{preset_sel, 4'h0} +: 16];
	wire [15:0] target = ctrl_r[`CW_JOG] ? jog_r : (ref_r != 16'h0000 ? ref_r : preset_ref);
	wire ready_start = ~tripped & ~coast_cmd & ~brake_cmd & ~qstop_cmd;

	// Frozen speed ignores start-bit stops, but coast and DC brake still win.
	always_comb begin
		state_nxt = state_r;
		if (tripped || coast_cmd) begin
			state_nxt = ST_COAST;
		end else if (brake_cmd) begin
			state_nxt = ST_DCBRAKE;
		end else if (frozen && state_r == ST_RUN) begin
			state_nxt = ST_RUN;
		end else if (qstop_cmd || !start_ok) begin
			state_nxt = (freq_r == 16'h0000) ? ST_STOPPED : ST_RAMPDOWN;
		end else begin
			state_nxt = ST_RUN;
		end
	end

	always_comb begin
		freq_nxt = freq_r;
		unique case (state_r)
			ST_RUN: begin
				if (frozen) begin
					if (term_in.speed_up && freq_r != 16'h7FFF) freq_nxt = freq_r + `RAMP_STEP;
					else if (term_in.speed_down && freq_r != 16'h8000) freq_nxt = freq_r - `RAMP_STEP;
				end else if ($signed(freq_r) < $signed(target)) begin
					freq_nxt = freq_r + `RAMP_STEP;
				end else if ($signed(freq_r) > $signed(target)) begin
					freq_nxt = freq_r - `RAMP_STEP;
				end
			end
			ST_RAMPDOWN: begin
				if ($signed(freq_r) > 0) freq_nxt = freq_r - `RAMP_STEP;
				else if ($signed(freq_r) < 0) freq_nxt = freq_r + `RAMP_STEP;
			end
			ST_STOPPED: freq_nxt = 16'h0000;
			ST_DCBRAKE: freq_nxt = 16'h0000;
			ST_COAST: freq_nxt = 16'h0000;
		endcase
	end

	// Unused status bits are built as constant zero.
	// Running follows the start command as well as the motor, so the master sees a start at once.
	wire stat_running = state_r == ST_RUN || start_ok;
	// Standby means every start condition holds while no start command is present yet.
	wire stat_standby = ready_start & ~start_ok;

	wire [15:0] status_nxt = {4'h0, stat_running, 3'h0,
		fault_in.warning,
		fault_in.trip_lock,
		2'h0,
		tripped,
		stat_standby,
		~tripped & coast_cmd,
		~tripped};

	wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_r} :
		hit_ref ? {16'h0000, ref_r} :
		hit_cfg ? config_r :
		hit_tmo ? timeout_r :
		hit_jog ? {16'h0000, jog_r} :
		hit_sts ? {16'h0000, status_r} :
		hit_frq ? {16'h0000, freq_r} :
		hit_drv ? {24'h000000, reverse_r, setup_r, dc_brake_r, output_on_r, relay2_r, relay1_r, 1'b0} :
		hit_flt ? {29'h0, fault_in.warning, fault_in.trip_lock, fault_in.trip} : 32'h0000_0000;

	// One wait state: ready is low in the first access cycle and high in the second, so every transfer takes three cycles.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= psel_in & penable_in & ~pready_r;
			pslverr_r <= psel_in & penable_in & ~pready_r & ~mapped;
			prdata_r <= (psel_in & penable_in & ~pready_r & ~pwrite_in) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_r <= `CTRL_RESET_VAL;
			ref_r <= 16'h0000;
			config_r <= `CONFIG_RESET_VAL;
			timeout_r <= `TIMEOUT_RESET_VAL;
			jog_r <= `JOG_RESET_VAL;
		end else begin
			if (cw_wr) ctrl_r <= pwdata_in[15:0];
			if (ref_wr) ref_r <= pwdata_in[15:0];
			if (apb_wr && hit_cfg) config_r <= pwdata_in;
			if (apb_wr && hit_tmo) timeout_r <= pwdata_in;
			if (apb_wr && hit_jog) jog_r <= pwdata_in[15:0];
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			idle_cnt_r <= 32'h0000_0000;
			prev_reset_r <= 1'b0;
			trip_pulse_r <= 1'b0;
			relay1_r <= 1'b0;
			relay2_r <= 1'b0;
			setup_r <= 2'h0;
			reverse_r <= 1'b0;
			state_r <= ST_STOPPED;
			freq_r <= 16'h0000;
			status_r <= 16'h0000;
			output_on_r <= 1'b0;
			dc_brake_r <= 1'b0;
		end else begin
			idle_cnt_r <= cw_wr ? 32'h0000_0000 : (timed_out ? idle_cnt_r : idle_cnt_r + 32'h0000_0001);
			if (cw_wr) prev_reset_r <= pwdata_in[`CW_RESET];
			trip_pulse_r <= cw_wr & pwdata_in[`CW_RESET] & ~prev_reset_r;
			if (timed_out) begin
				relay1_r <= 1'b0;
				relay2_r <= 1'b0;
			end else begin
				relay1_r <= config_r[`CFG_RELAY1_BUS] & ctrl_r[`CW_RELAY1];
				relay2_r <= config_r[`CFG_RELAY2_BUS] & ctrl_r[`CW_RELAY2];
			end
			setup_r <= cfg_multi ? ctrl_r[`CW_SETUP_LO +: 2] : 2'h0;
			reverse_r <= (rev_src == SRC_DIGITAL) ? term_in.reverse : gate_src(rev_src,
				ctrl_r[`CW_REVERSE], term_in.reverse);
			state_r <= state_nxt;
			freq_r <= freq_nxt;
			status_r <= status_nxt;
			// Decoded from the next state so the pins switch with the state register, not a cycle later.
			output_on_r <= state_nxt == ST_RUN || state_nxt == ST_RAMPDOWN;
			dc_brake_r <= state_nxt == ST_DCBRAKE;
		end
	end

	assign prdata_out = prdata_r;
	assign pready_out = pready_r;
	assign pslverr_out = pslverr_r;
	assign relay1_out = relay1_r;
	assign relay2_out = relay2_r;
	assign setup_out = setup_r;
	assign reverse_out = reverse_r;
	assign trip_reset_out = trip_pulse_r;
	assign output_on_out = output_on_r;
	assign dc_brake_out = dc_brake_r;

	chk_trip_reset_edge: assert property (@(posedge mclk_in) disable iff (rst_in)
		trip_pulse_r |-> $past(cw_wr) && $past(pwdata_in[`CW_RESET]) && !$past(prev_reset_r))
		else $error("Trip reset without a rising reset bit.");
	chk_invalid_ignored: assert property (@(posedge mclk_in) disable iff (rst_in)
		(apb_wr && hit_ctrl && !pwdata_in[`CW_VALID]) |=> $stable(ctrl_r))
		else $error("Control word without valid bit was taken.");
	chk_coast_off: assert property (@(posedge mclk_in) disable iff (rst_in)
		(!ctrl_r[`CW_COAST] && $stable(ctrl_r)) |=> state_r == ST_COAST)
		else $error("Coast bit low did not turn the output off.");
	chk_brake_state: assert property (@(posedge mclk_in) disable iff (rst_in)
		(!ctrl_r[`CW_DCBRAKE] && !coast_cmd && !tripped) |=> state_r == ST_DCBRAKE)
		else $error("Brake bit low did not brake.");
	chk_relay_timeout: assert property (@(posedge mclk_in) disable iff (rst_in)
		timed_out |=> !relay1_r && !relay2_r)
		else $error("Relay held after bus timeout.");
	chk_relay_config: assert property (@(posedge mclk_in) disable iff (rst_in)
		!$past(config_r[`CFG_RELAY1_BUS]) |-> !relay1_r)
		else $error("Relay 1 driven without bus configuration.");
	chk_setup_single: assert property (@(posedge mclk_in) disable iff (rst_in)
		!$past(cfg_multi) |-> setup_r == 2'h0)
		else $error("Setup changed without multi-setup.");
	chk_status_trip: assert property (@(posedge mclk_in) disable iff (rst_in)
		$past(tripped) |-> status_r[3] && !status_r[0])
		else $error("Trip not shown in status.");
	chk_status_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
		status_r[5:4] == 2'h0 && status_r[12] == 1'b0)
		else $error("Unused status bits not zero.");
	chk_apb_ready: assert property (@(posedge mclk_in) disable iff (rst_in)
		apb_setup ##1 (psel_in && penable_in) |=> pready_r)
		else $error("APB answer not in one wait state.");
	chk_pready_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
		pready_r |=> !pready_r)
		else $error("Ready stood longer than one cycle.");
	chk_apb_error: assert property (@(posedge mclk_in) disable iff (rst_in)
		pready_r |-> pslverr_r == !mapped)
		else $error("Error flag does not match the address map.");

	// Register writes: what is taken, what is dropped.
	chk_ctrl_taken: assert property (@(posedge mclk_in) disable iff (rst_in)
		cw_wr |=> ctrl_r == $past(pwdata_in[15:0]))
		else $error("Valid control word not stored.");
	chk_ref_taken: assert property (@(posedge mclk_in) disable iff (rst_in)
		ref_wr |=> ref_r == $past(pwdata_in[15:0]))
		else $error("Reference not stored.");
	chk_ref_gated: assert property (@(posedge mclk_in) disable iff (rst_in)
		(apb_wr && hit_ref && !ctrl_r[`CW_VALID]) |=> $stable(ref_r))
		else $error("Reference taken without a valid control word.");
	chk_idle_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
		cw_wr |=> idle_cnt_r == 32'h0000_0000)
		else $error("Bus idle counter not cleared by a valid word.");

	// Reference selection and the motor state machine.
	chk_preset_sel: assert property (@(posedge mclk_in) disable iff (rst_in)
		(ctrl_r[1:0] == 2'h1 && !ctrl_r[`CW_JOG] && ref_r == 16'h0000) |-> target == presets_in[31:16])
		else $error("Preset 2 not selected.");
	chk_jog_target: assert property (@(posedge mclk_in) disable iff (rst_in)
		ctrl_r[`CW_JOG] |-> target == jog_r)
		else $error("Jog frequency not used as target.");
	chk_freeze_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
		(state_r == ST_RUN && frozen && !term_in.speed_up && !term_in.speed_down) |=> freq_r == $past(freq_r))
		else $error("Frozen frequency moved.");
	chk_frozen_run: assert property (@(posedge mclk_in) disable iff (rst_in)
		(state_r == ST_RUN && frozen && !tripped && !coast_cmd && !brake_cmd) |=> state_r == ST_RUN)
		else $error("Frozen drive stopped without coast or brake.");
	chk_qstop_ramp: assert property (@(posedge mclk_in) disable iff (rst_in)
		(state_r == ST_RUN && !frozen && qstop_cmd && !tripped && !coast_cmd && !brake_cmd &&
		freq_r != 16'h0000) |=> state_r == ST_RAMPDOWN)
		else $error("Quick stop did not ramp down.");
	chk_ramp_step: assert property (@(posedge mclk_in) disable iff (rst_in)
		(state_r == ST_RAMPDOWN && $signed(freq_r) > 0) |=> freq_r == $past(freq_r) - 16'h0001)
		else $error("Ramp down step wrong.");
	chk_start_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
		(state_r == ST_STOPPED && !start_ok) |=> state_r != ST_RUN)
		else $error("Motor started without a start command.");
	chk_coast_output: assert property (@(posedge mclk_in) disable iff (rst_in)
		coast_cmd |=> !output_on_out)
		else $error("Output stage on while coasting.");
	chk_brake_out: assert property (@(posedge mclk_in) disable iff (rst_in)
		(brake_cmd && !tripped && !coast_cmd) |=> dc_brake_out)
		else $error("Brake output not driven.");
	chk_brake_freq: assert property (@(posedge mclk_in) disable iff (rst_in)
		state_r == ST_DCBRAKE |=> freq_r == 16'h0000)
		else $error("Frequency not zero while braking.");
	chk_trip_coast: assert property (@(posedge mclk_in) disable iff (rst_in)
		tripped |=> state_r == ST_COAST)
		else $error("Trip did not release the motor.");

	// Relays, setup and direction.
	chk_relay_set: assert property (@(posedge mclk_in) disable iff (rst_in)
		(config_r[`CFG_RELAY1_BUS] && ctrl_r[`CW_RELAY1] && !timed_out) |=> relay1_r)
		else $error("Relay 1 not energised.");
	chk_setup_multi: assert property (@(posedge mclk_in) disable iff (rst_in)
		cfg_multi |=> setup_r == $past(ctrl_r[`CW_SETUP_LO +: 2]))
		else $error("Setup bits not applied.");
	chk_reverse_digital: assert property (@(posedge mclk_in) disable iff (rst_in)
		rev_src == SRC_DIGITAL |=> reverse_r == $past(term_in.reverse))
		else $error("Reverse bit used with digital source.");

	// Status word flags lag their causes by one cycle.
	chk_status_ready: assert property (@(posedge mclk_in) disable iff (rst_in)
		!tripped |=> status_r[0])
		else $error("Ready flag missing.");
	chk_status_lock: assert property (@(posedge mclk_in) disable iff (rst_in)
		fault_in.trip_lock |=> status_r[6])
		else $error("Trip lock not shown.");
	chk_status_warn: assert property (@(posedge mclk_in) disable iff (rst_in)
		fault_in.warning |=> status_r[7])
		else $error("Warning not shown.");

	cov_start_run: cover property (@(posedge mclk_in) disable iff (rst_in) state_r == ST_STOPPED ##1 state_r == ST_RUN);
	cov_ramp_down: cover property (@(posedge mclk_in) disable iff (rst_in) state_r == ST_RAMPDOWN);
	cov_timeout: cover property (@(posedge mclk_in) disable iff (rst_in) timed_out && $past(relay1_r));
	cov_freeze_hold: cover property (@(posedge mclk_in) disable iff (rst_in) state_r == ST_RUN && frozen && !start_ok);
	cov_jog_run: cover property (@(posedge mclk_in) disable iff (rst_in) state_r == ST_RUN && ctrl_r[`CW_JOG]);
endmodule
`default_nettype wire

/* hdl/drive_ctl_defines.svh */
// Register offsets, field positions, reset values and the frequency scale and ramp step for the drive control word block.
// Assumes a 100 MHz clock and a 32-bit APB register bus.
`ifndef DRIVE_CTL_DEFINES_SVH
`define DRIVE_CTL_DEFINES_SVH
`define OFS_CTRL_IN 12'h000
`define OFS_REF_IN 12'h004
`define OFS_CONFIG 12'h008
`define OFS_TIMEOUT 12'h00C
`define OFS_STATUS 12'h010
`define OFS_OUTFREQ 12'h014
`define OFS_DRIVE 12'h018
`define OFS_FAULT 12'h01C
`define OFS_JOG 12'h020
`define CW_PRESET_LO 0
`define CW_DCBRAKE 2
`define CW_COAST 3
`define CW_QSTOP 4
`define CW_FREEZE 5
`define CW_START 6
`define CW_RESET 7
`define CW_JOG 8
`define CW_VALID 10
`define CW_RELAY1 11
`define CW_RELAY2 12
`define CW_SETUP_LO 13
`define CW_REVERSE 15
`define CFG_RELAY1_BUS 0
`define CFG_RELAY2_BUS 1
`define CFG_MULTI_SETUP 2
`define CFG_REV_SRC_LO 3
`define CFG_START_SRC_LO 5
`define CTRL_RESET_VAL 16'h0000
`define CONFIG_RESET_VAL 32'h0000_0000
`define TIMEOUT_RESET_VAL 32'h0000_0000
`define JOG_RESET_VAL 16'h0000
`define FULL_SCALE 16'h4000
`define RAMP_STEP 16'h0001
`endif

/* hdl/drive_ctl_pkg.sv */
// Types shared by the drive control word block.
// Assumes nothing of its surroundings.
`default_nettype none
package drive_ctl_pkg;
	typedef enum logic [1:0] {
		SRC_DIGITAL = 2'h0,
		SRC_BUS = 2'h1,
		SRC_AND = 2'h2,
		SRC_OR = 2'h3
	} src_sel_t;
	typedef enum logic [4:0] {
		ST_STOPPED = 5'h01,
		ST_RUN = 5'h02,
		ST_RAMPDOWN = 5'h04,
		ST_DCBRAKE = 5'h08,
		ST_COAST = 5'h10
	} motor_state_t;
	typedef struct packed {
		logic coast_n;
		logic start;
		logic dcbrake_n;
		logic speed_up;
		logic speed_down;
		logic [1:0] setup;
		logic reverse;
	} terminals_t;
	typedef struct packed {
		logic trip;
		logic trip_lock;
		logic warning;
	} faults_t;
endpackage
`default_nettype wire

/* testbench/apb_host_model.sv */
// APB master standing in for the serial-link master that sends process data to the drive.
// Assumes one clock shared with the slave; waits on pready with no cycle budget of its own.
`include "drive_ctl_defines.svh"
`default_nettype none
module apb_host_model (
	input wire logic mclk_in,
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [11:0] paddr_out,
	output logic [31:0] pwdata_out,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 12'h000;
		pwdata_out = 32'h0000_0000;
	end
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge mclk_in);
		psel_out <= 1'b1;
		pwrite_out <= wr;
		paddr_out <= a;
		pwdata_out <= wd;
		@(posedge mclk_in);
		penable_out <= 1'b1;
		do begin
			@(posedge mclk_in);
		end while (pready_in !== 1'b1);
		rd = prdata_in;
		err = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		// Released data is inverted so a slave that samples late cannot see a stale match.
		pwdata_out <= ~wd;
	endtask
	// Control word always goes before the signed reference, as one process-data block.
	task automatic send_pd(input logic [15:0] cw, input logic [15:0] ref_v);
		logic [31:0] rd;
		logic err;
		xfer(1'b1, `OFS_CTRL_IN, {16'h0000, cw}, rd, err);
		xfer(1'b1, `OFS_REF_IN, {16'h0000, ref_v}, rd, err);
	endtask
endmodule
`default_nettype wire

/* testbench/drive_ctl_bench.sv */
// Self-checking bench for the drive control word block.
// Assumes the APB host model drives the bus; terminals and faults are driven here.
`include "drive_ctl_defines.svh"
`default_nettype none
module drive_ctl_bench;
	import drive_ctl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	terminals_t term = '0;
	faults_t fault = '0;
	logic [63:0] presets = 64'h0000_0000_0000_0000;
	logic relay1, relay2, out_on, brake, rev, trip_rst;
	logic [1:0] setup;
	int err_total = 0;
	int n_checks = 0;
	int pulses = 0;
	always #5 mclk = ~mclk;
	always @(posedge mclk) if (trip_rst === 1'b1) pulses <= pulses + 1;
	apb_host_model i_apb_host_model (.mclk_in(mclk), .psel_out(psel), .penable_out(penable),
		.pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
		.pready_in(pready), .pslverr_in(pslverr));
	drive_ctl i_drive_ctl (.mclk_in(mclk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .term_in(term), .fault_in(fault),
		.presets_in(presets), .relay1_out(relay1), .relay2_out(relay2), .output_on_out(out_on),
		.dc_brake_out(brake), .reverse_out(rev), .setup_out(setup), .trip_reset_out(trip_rst));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_apb_host_model.xfer(1'b1, a, d, rd, er);
	endtask
	task automatic rdr(input logic [11:0] a);
		i_apb_host_model.xfer(1'b0, a, 32'h0000_0000, rd, er);
	endtask
	task automatic t_regs();
		rdr(`OFS_CTRL_IN);
		check(rd, {16'h0000, `CTRL_RESET_VAL});
		rdr(12'h0FC);
		check({31'h0, er}, 32'h0000_0001);
		check(rd, 32'h0000_0000);
		wr(`OFS_CTRL_IN, 32'h0000_043C);
		wr(`OFS_CTRL_IN, 32'h0000_003F);
		rdr(`OFS_CTRL_IN);
		check(rd, 32'h0000_043C);
	endtask
	task automatic t_relay();
		wr(`OFS_CONFIG, 32'h0000_0003);
		wr(`OFS_CTRL_IN, 32'h0000_183C);
		check({relay2, relay1}, 2'h0);
		wr(`OFS_CTRL_IN, 32'h0000_1C3C);
		repeat (2) @(posedge mclk);
		check({relay2, relay1}, 2'h3);
		wr(`OFS_CONFIG, 32'h0000_0000);
		wr(`OFS_CTRL_IN, 32'h0000_1C3C);
		repeat (2) @(posedge mclk);
		check({relay2, relay1}, 2'h0);
		wr(`OFS_CONFIG, 32'h0000_0003);
		wr(`OFS_TIMEOUT, 32'h0000_0014);
		wr(`OFS_CTRL_IN, 32'h0000_1C3C);
		repeat (5) @(posedge mclk);
		check({relay2, relay1}, 2'h3);
		repeat (30) @(posedge mclk);
		check({relay2, relay1}, 2'h0);
		wr(`OFS_TIMEOUT, 32'h0000_0000);
	endtask
	task automatic t_trip_reset();
		wr(`OFS_CTRL_IN, 32'h0000_043C);
		pulses = 0;
		wr(`OFS_CTRL_IN, 32'h0000_04BC);
		wr(`OFS_CTRL_IN, 32'h0000_04BC);
		wr(`OFS_CTRL_IN, 32'h0000_003C);
		wr(`OFS_CTRL_IN, 32'h0000_04BC);
		repeat (3) @(posedge mclk);
		check(pulses, 1);
	endtask
	task automatic t_setup_rev();
		wr(`OFS_CONFIG, 32'h0000_000C);
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_CTRL_IN, 32'h0000_043C | (i << 13));
			repeat (2) @(posedge mclk);
			check(setup, i[1:0]);
		end
		wr(`OFS_CTRL_IN, 32'h0000_843C);
		repeat (2) @(posedge mclk);
		check(rev, 1'b1);
		wr(`OFS_CONFIG, 32'h0000_0000);
		wr(`OFS_CTRL_IN, 32'h0000_843C);
		repeat (2) @(posedge mclk);
		check(rev, 1'b0);
	endtask
	task automatic t_status();
		for (int i = 0; i < 8; i++) begin
			fault <= i[2:0];
			repeat (3) @(posedge mclk);
			rdr(`OFS_STATUS);
			check(rd & 32'h0000_10F9, {24'h0, i[0], i[1], 2'h0, i[2] | i[1], 2'h0, ~(i[2] | i[1])});
		end
		fault <= '0;
	endtask
	task automatic t_motion();
		term <= '{coast_n: 1'b1, start: 1'b1, dcbrake_n: 1'b1, default: 1'b0};
		wr(`OFS_CONFIG, 32'h0000_0020);
		i_apb_host_model.send_pd(16'h047C, 16'h0010);
		rdr(`OFS_REF_IN);
		check(rd, 32'h0000_0010);
		repeat (3) @(posedge mclk);
		check(out_on, 1'b1);
		wr(`OFS_CTRL_IN, 32'h0000_0474);
		repeat (3) @(posedge mclk);
		check(out_on, 1'b0);
		wr(`OFS_CTRL_IN, 32'h0000_047C);
		repeat (3) @(posedge mclk);
		wr(`OFS_CTRL_IN, 32'h0000_0478);
		repeat (3) @(posedge mclk);
		check({brake, out_on}, 2'h2);
		wr(`OFS_CTRL_IN, 32'h0000_047C);
		repeat (40) @(posedge mclk);
		wr(`OFS_CTRL_IN, 32'h0000_043C);
		repeat (40) @(posedge mclk);
		check(out_on, 1'b0);
	endtask
	task automatic t_freq();
		presets <= 64'h0004_0003_0002_0001;
		i_apb_host_model.send_pd(16'h047D, 16'h0000);
		repeat (20) @(posedge mclk);
		rdr(`OFS_OUTFREQ);
		check(rd, 32'h0000_0002);
		wr(`OFS_JOG, 32'h0000_0005);
		wr(`OFS_CTRL_IN, 32'h0000_057C);
		repeat (10) @(posedge mclk);
		rdr(`OFS_OUTFREQ);
		check(rd, 32'h0000_0005);
		wr(`OFS_CTRL_IN, 32'h0000_055C);
		wr(`OFS_CTRL_IN, 32'h0000_051C);
		repeat (5) @(posedge mclk);
		check(out_on, 1'b1);
		rdr(`OFS_OUTFREQ);
		check(rd, 32'h0000_0005);
		wr(`OFS_CTRL_IN, 32'h0000_0514);
		rdr(`OFS_STATUS);
		check(rd & 32'h0000_0003, 32'h0000_0003);
		check(out_on, 1'b0);
		wr(`OFS_CTRL_IN, 32'h0000_057C);
		repeat (10) @(posedge mclk);
		wr(`OFS_CTRL_IN, 32'h0000_056C);
		repeat (20) @(posedge mclk);
		check(out_on, 1'b0);
	endtask
	task automatic t_reset();
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		check({relay2, relay1, out_on}, 3'h0);
		rst <= 1'b0;
		rdr(`OFS_CTRL_IN);
		check(rd, {16'h0000, `CTRL_RESET_VAL});
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_relay();
		t_trip_reset();
		t_setup_rev();
		t_status();
		t_motion();
		t_freq();
		t_reset();
		summarize();
	end
endmodule
`default_nettype wire
